// ==== cpu_register_set.sv ====
// Core register set: accumulator, two index registers, fetch address,
// condition flags, stack pointer and context push/pop sequencing.
// Assumes the decoder holds off new operations while busy_o is high.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_set
   import cpu_regs_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   // Decoder and ALU request
   input  wire reg_req_type       req_i,
   // Interrupt sequencer
   input  wire logic              irq_request_i,
   input  wire logic              trap_request_i,
   // Register views
   output logic [7:0]             acc_o,
   output logic [7:0]             index_first_o,
   output logic [7:0]             index_second_o,
   output logic [15:0]            fetch_address_register_o,
   output logic [7:0]             condition_flags_o,
   output logic [15:0]            stack_pointer_o,
   // Sequencing status
   output logic                   busy_o,
   output logic                   irq_take_o
);

   // Sequencer for multi-byte stack transfers
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_PUSH,
      SEQ_POP
   } seq_state_type;

   seq_state_type  state_reg, state_next;
   logic [7:0]     acc_reg, acc_next;
   logic [7:0]     ix_reg, ix_next;
   logic [7:0]     iy_reg, iy_next;
   logic [15:0]    fetch_reg, fetch_next;
   logic [7:0]     flags_reg, flags_next;
   logic [6:0]     sp_reg, sp_next;
   logic [2:0]     step_reg, step_next;
   logic [2:0]     count_reg, count_next;
   logic           irq_kind_reg, irq_kind_next;
   logic           pend_reg, pend_next;
   logic           take_reg, take_next;
   logic           pop_valid_reg, pop_valid_next;
   logic [2:0]     pop_slot_reg, pop_slot_next;
   stack_req_type  stack_req;
   logic [7:0]     stack_rdata;

   // Byte pushed at a given step of an interrupt entry or call
   function automatic logic [7:0] push_byte(input logic [2:0] step,
                                            input logic [15:0] fa,
                                            input logic [7:0] x,
                                            input logic [7:0] a,
                                            input logic [7:0] f);
      case (step)
         3'h0:    push_byte = fa[7:0];
         3'h1:    push_byte = fa[15:8];
         3'h2:    push_byte = x;
         3'h3:    push_byte = a;
         default: push_byte = f;
      endcase
   endfunction : push_byte

   // Result flag update shared by the ALU, add and shift operations; plain loads other than the flags load leave flags alone
   function automatic logic [7:0] result_flags(input logic [7:0] f,
                                               input logic [7:0] res);
      logic [7:0] r;
      r = f;
      r[FLAG_N] = res[7];
      r[FLAG_Z] = (res == 8'h00);
      return r;
   endfunction : result_flags

   // Read data registered: each popped byte lands a cycle late
   stack_ram #(
      .DEPTH_W (STACK_IDX_W)
   ) u_stack (
      .ref_clk_i (ref_clk_i),
      .req_i     (stack_req),
      .rdata_o   (stack_rdata)
   );

   // Register updates and sequencing
   always_comb begin
      state_next     = state_reg;
      acc_next       = acc_reg;
      ix_next        = ix_reg;
      iy_next        = iy_reg;
      fetch_next     = fetch_reg;
      flags_next     = flags_reg;
      sp_next        = sp_reg;
      step_next      = step_reg;
      count_next     = count_reg;
      irq_kind_next  = irq_kind_reg;
      // Take pulse lasts one cycle
      take_next      = 1'b0;
      pop_valid_next = 1'b0;
      pop_slot_next  = step_reg;
      stack_req      = '0;
      // Pending latch; new request wins over the take
      pend_next = pend_reg | irq_request_i;
      // Popped byte lands one cycle after its read
      if (pop_valid_reg) begin
         case (pop_slot_reg)
            3'h0:    flags_next = stack_rdata;
            3'h1:    acc_next = stack_rdata;
            3'h2:    ix_next = stack_rdata;
            3'h3:    fetch_next[15:8] = stack_rdata;
            default: fetch_next[7:0] = stack_rdata;
         endcase
      end
      // Interrupts are taken only between operations, never mid-sequence
      case (state_reg)
         SEQ_IDLE: begin
            // Trap ignores the mask; masked requests wait
            if (trap_request_i ||
                (pend_next && !flags_reg[FLAG_I])) begin
               state_next    = SEQ_PUSH;
               step_next     = 3'h0;
               count_next    = IRQ_BYTES;
               irq_kind_next = 1'b1;
               take_next     = 1'b1;
               if (!trap_request_i) begin
                  pend_next = irq_request_i;
               end
            end else if (!pop_valid_reg) begin
               // Refused while the last popped byte still lands
               case (req_i.op)
                  OP_ALU, OP_ADD, OP_SHIFT: begin
                     acc_next = req_i.data;
                     flags_next = result_flags(flags_reg, req_i.data);
                     if (req_i.op == OP_ADD) begin
                        flags_next[FLAG_H] = req_i.half_carry;
                     end
                     if (req_i.op != OP_ALU) begin
                        flags_next[FLAG_C] = req_i.carry;
                     end
                  end
                  OP_CARRY_SET:   flags_next[FLAG_C] = 1'b1;
                  OP_CARRY_CLEAR: flags_next[FLAG_C] = 1'b0;
                  OP_MASK_SET:    flags_next[FLAG_I] = 1'b1;
                  OP_UNMASK:      flags_next[FLAG_I] = 1'b0;
                  OP_STACK_REINIT: sp_next = STACK_TOP[6:0];
                  OP_LOAD_SP_LOW: sp_next = req_i.data[6:0];
                  OP_CALL: begin
                     state_next    = SEQ_PUSH;
                     step_next     = 3'h0;
                     count_next    = CALL_BYTES;
                     irq_kind_next = 1'b0;
                     fetch_next    = req_i.fetch_addr;
                  end
                  OP_RETURN: begin
                     // Call return pops high then low: start at slot three
                     state_next = SEQ_POP;
                     step_next  = 3'h3;
                     count_next = CALL_BYTES;
                  end
                  OP_HANDLER_RETURN: begin
                     // Flags come back first; second index never stacked
                     state_next = SEQ_POP;
                     step_next  = 3'h0;
                     count_next = IRQ_BYTES;
                  end
                  default: begin
                     // Plain loads of the register views, no address map
                     case (req_i.dst)
                        DST_ACC: acc_next = req_i.data;
                        DST_INDEX: begin
                           if (req_i.use_second_index) begin
                              iy_next = req_i.data;
                           end else begin
                              ix_next = req_i.data;
                           end
                        end
                        DST_FETCH: fetch_next = req_i.fetch_addr;
                        // Whole byte, mask included
                        DST_FLAGS: flags_next = req_i.data;
                        default: ;
                     endcase
                  end
               endcase
            end
         end
         SEQ_PUSH: begin
            // Low fetch byte first at current pointer, then downward
            // Mask set with the last push so the old mask is saved
            stack_req.wr    = 1'b1;
            stack_req.idx   = sp_reg;
            stack_req.wdata = push_byte(step_reg, fetch_reg, ix_reg,
                                        acc_reg, flags_reg);
            sp_next    = sp_reg - 7'h01;
            step_next  = step_reg + 3'h1;
            count_next = count_reg - 3'h1;
            if (count_reg == 3'h1) begin
               state_next = SEQ_IDLE;
               if (irq_kind_reg) begin
                  flags_next[FLAG_I] = 1'b1;
               end
            end
         end
         SEQ_POP: begin
            // Increment before each read; wraps at the top silently
            sp_next       = sp_reg + 7'h01;
            stack_req.rd  = 1'b1;
            stack_req.idx = sp_reg + 7'h01;
            pop_valid_next = 1'b1;
            pop_slot_next  = step_reg;
            step_next  = step_reg + 3'h1;
            count_next = count_reg - 3'h1;
            if (count_reg == 3'h1) begin
               state_next = SEQ_IDLE;
            end
         end
         default: state_next = SEQ_IDLE;
      endcase
   end

   // Synchronous reset; undefined reset flag bits driven to one
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         state_reg     <= SEQ_IDLE;
         acc_reg       <= 8'h00;
         ix_reg        <= 8'h00;
         iy_reg        <= 8'h00;
         fetch_reg     <= FETCH_RESET;
         flags_reg     <= FLAGS_RESET;
         sp_reg        <= STACK_TOP[6:0];
         step_reg      <= 3'h0;
         count_reg     <= 3'h0;
         irq_kind_reg  <= 1'b0;
         pend_reg      <= 1'b0;
         take_reg      <= 1'b0;
         pop_valid_reg <= 1'b0;
         pop_slot_reg  <= 3'h0;
      end else begin
         state_reg     <= state_next;
         acc_reg       <= acc_next;
         ix_reg        <= ix_next;
         iy_reg        <= iy_next;
         fetch_reg     <= fetch_next;
         flags_reg     <= flags_next;
         sp_reg        <= sp_next;
         step_reg      <= step_next;
         count_reg     <= count_next;
         irq_kind_reg  <= irq_kind_next;
         pend_reg      <= pend_next;
         take_reg      <= take_next;
         pop_valid_reg <= pop_valid_next;
         pop_slot_reg  <= pop_slot_next;
      end
   end

   // Views straight from flip-flops; busy covers the trailing pop write
   assign acc_o                    = acc_reg;
   assign index_first_o            = ix_reg;
   assign index_second_o           = iy_reg;
   assign fetch_address_register_o = fetch_reg;
   assign condition_flags_o        = flags_reg;
   assign stack_pointer_o          = {STACK_FIXED, sp_reg};
   assign irq_take_o               = take_reg;

   logic busy_reg;
   logic busy_next;
   always_comb begin
      busy_next = (state_next != SEQ_IDLE) || pop_valid_next;
   end
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= busy_next;
      end
   end
   assign busy_o = busy_reg;

endmodule : cpu_register_set
`default_nettype wire

// ==== cpu_regs_pkg.sv ====
// Package for the core register set: widths, reset values, operations.
// Assumes a single core clock and a synchronous active-low reset.
package cpu_regs_pkg;

   localparam int         DATA_W        = 8;
   localparam int         ADDR_W        = 16;
   localparam int         STACK_IDX_W   = 7;
   localparam logic [15:0] STACK_TOP    = 16'h01ff;
   localparam logic [8:0]  STACK_FIXED  = 9'h003;
   localparam logic [7:0]  FLAGS_RESET  = 8'he8;
   localparam logic [15:0] FETCH_RESET  = 16'h0000;
   localparam int         FLAG_C        = 0;
   localparam int         FLAG_Z        = 1;
   localparam int         FLAG_N        = 2;
   localparam int         FLAG_I        = 3;
   localparam int         FLAG_H        = 4;
   localparam logic [2:0] CALL_BYTES    = 3'h2;
   localparam logic [2:0] IRQ_BYTES     = 3'h5;

   // Operations issued by the instruction decoder
   typedef enum logic [3:0] {
      OP_NONE,
      OP_ALU,
      OP_ADD,
      OP_SHIFT,
      OP_CARRY_SET,
      OP_CARRY_CLEAR,
      OP_MASK_SET,
      OP_UNMASK,
      OP_STACK_REINIT,
      OP_LOAD_SP_LOW,
      OP_CALL,
      OP_RETURN,
      OP_IRQ_ENTRY,
      OP_HANDLER_RETURN
   } reg_op_type;

   // Target selection for register loads
   typedef enum logic [2:0] {
      DST_NONE,
      DST_ACC,
      DST_INDEX,
      DST_FETCH,
      DST_FLAGS
   } reg_dst_type;

   // Request from the decoder and ALU
   typedef struct packed {
      reg_op_type  op;
      reg_dst_type dst;
      logic        use_second_index;
      logic [7:0]  data;
      logic [15:0] fetch_addr;
      logic        carry;
      logic        half_carry;
   } reg_req_type;

   // Stack memory write or read request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] idx;
      logic [7:0] wdata;
   } stack_req_type;

endpackage : cpu_regs_pkg

// ==== stack_ram.sv ====
// Stack memory of 128 bytes with registered read data.
// Assumes one clock; write and read never address different words in a cycle.
`timescale 1ns/100ps
`default_nettype none
module stack_ram
   import cpu_regs_pkg::*;
#(
   parameter int DEPTH_W = STACK_IDX_W
) (
   // Clock
   input  wire logic              ref_clk_i,
   // Access
   input  wire stack_req_type     req_i,
   output logic [DATA_W-1:0]      rdata_o
);

   logic [DATA_W-1:0] mem_reg [0:(1<<DEPTH_W)-1];
   logic [DATA_W-1:0] rdata_reg;

   // No reset on the array; contents are undefined until pushed
   always_ff @(posedge ref_clk_i) begin
      if (req_i.wr) begin
         mem_reg[req_i.idx[DEPTH_W-1:0]] <= req_i.wdata;
      end
      if (req_i.rd) begin
         rdata_reg <= mem_reg[req_i.idx[DEPTH_W-1:0]];
      end
   end

   assign rdata_o = rdata_reg;

endmodule : stack_ram
`default_nettype wire

// ==== irq_source.sv ====
// Partner model: peripheral that raises one interrupt pulse per event.
// Assumes the core latches a pulse as pending by itself.
`timescale 1ns/100ps
`default_nettype none
module irq_source (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_b_i,
   // Event from the bench
   input  wire logic fire_i,
   // Request to the core
   output logic      irq_request_o
);
   logic pulse_next;
   // Pulse, not level: a held level would pend again after the take
   always_comb begin
      pulse_next = fire_i && !irq_request_o;
   end
   always_ff @(posedge ref_clk_i) begin
      irq_request_o <= rst_b_i && pulse_next;
   end
endmodule : irq_source
`default_nettype wire

// ==== cpu_register_set_chk.sv ====
// Checker: flag, stack and entry relations of the register set.
// Assumes it is bound to cpu_register_set and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_set_chk
   import cpu_regs_pkg::*;
(
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        rst_b_i,
   // Inputs
   input wire reg_req_type req_i,
   input wire logic        trap_request_i,
   // Outputs
   input wire logic [7:0]  index_second_o,
   input wire logic [7:0]  condition_flags_o,
   input wire logic [15:0] stack_pointer_o,
   input wire logic        busy_o,
   input wire logic        irq_take_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic idle;
   assign idle = !busy_o;

   a_sp_upper_fixed: assert property (stack_pointer_o[15:7] == 9'h003)
      else $error("stack pointer upper bits moved");
   a_reset_load: assert property ($rose(rst_b_i) |->
      condition_flags_o == 8'he8 && stack_pointer_o == 16'h01ff)
      else $error("reset values wrong");
   a_mask_blocks: assert property (irq_take_o |->
      !$past(condition_flags_o[3]) || $past(trap_request_i))
      else $error("interrupt taken under mask");
   a_entry_busy: assert property (irq_take_o |-> busy_o[*5] ##1 !busy_o)
      else $error("entry length wrong");
   a_entry_depth: assert property (irq_take_o |-> ##5
      stack_pointer_o[6:0] == $past(stack_pointer_o[6:0], 6) - 7'h05)
      else $error("entry stack depth wrong");
   a_entry_mask: assert property (irq_take_o |-> ##5 condition_flags_o[3])
      else $error("mask not set on entry");
   a_second_kept: assert property (irq_take_o |-> ##5
      index_second_o == $past(index_second_o, 6))
      else $error("second index changed by entry");
   a_nz_follow: assert property (idle && req_i.op == OP_ALU |=>
      irq_take_o || condition_flags_o[2:1] ==
      {$past(req_i.data[7]), $past(req_i.data) == 8'h00})
      else $error("negative or zero flag wrong");
   a_half_carry: assert property (idle && req_i.op == OP_ADD |=>
      irq_take_o || {condition_flags_o[4], condition_flags_o[0]} ==
      $past({req_i.half_carry, req_i.carry}))
      else $error("half carry or carry wrong");
   a_carry_clear: assert property (idle && req_i.op == OP_CARRY_CLEAR |=>
      irq_take_o || !condition_flags_o[0])
      else $error("carry not cleared");
   a_unmask_op: assert property (idle && req_i.op == OP_UNMASK |=>
      irq_take_o || !condition_flags_o[3])
      else $error("mask not cleared");

   c_take: cover property (irq_take_o);
   c_call: cover property (idle && req_i.op == OP_CALL);
   c_hret: cover property (idle && req_i.op == OP_HANDLER_RETURN);
endmodule : cpu_register_set_chk
bind cpu_register_set cpu_register_set_chk chk_u (.ref_clk_i, .rst_b_i,
   .req_i, .trap_request_i, .index_second_o, .condition_flags_o,
   .stack_pointer_o, .busy_o, .irq_take_o);
`default_nettype wire

// ==== cpu_register_set_bench.sv ====
// Bench: decoder requests and interrupt events, register views checked.
// Assumes cpu_register_set, its checker and the irq_source model.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_set_bench
   import cpu_regs_pkg::*;
;
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   reg_req_type req = '0;
   logic        fire = 1'b0;
   logic        trap = 1'b0;
   logic        irq;
   logic [7:0]  acc, xi, yi, fl;
   logic [15:0] fa, sp;
   logic        busy, take;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          take_cnt = 0;

   always #25 clk = ~clk;
   cpu_register_set dut_u (.ref_clk_i(clk), .rst_b_i(rst_b), .req_i(req),
      .irq_request_i(irq), .trap_request_i(trap), .acc_o(acc),
      .index_first_o(xi), .index_second_o(yi),
      .fetch_address_register_o(fa), .condition_flags_o(fl),
      .stack_pointer_o(sp), .busy_o(busy), .irq_take_o(take));
   irq_source irq_u (.ref_clk_i(clk), .rst_b_i(rst_b), .fire_i(fire),
      .irq_request_o(irq));

   // Entry pulses seen, sampled mid-cycle
   always @(negedge clk) begin
      if (take === 1'b1) take_cnt++;
   end

   function automatic logic [1:0] nz(input logic [7:0] v);
      return {v[7], v == 8'h00};
   endfunction : nz

   task automatic chk(input string w, input logic [15:0] e,
                      input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", w, e, g);
      end
   endtask : chk

   // One request, then wait out any sequence it starts
   task automatic op(input reg_op_type o, input reg_dst_type d = DST_NONE,
                     input logic s = 1'b0, input logic [7:0] v = 8'h00,
                     input logic [15:0] f = 16'h0000,
                     input logic [1:0] k = 2'b00);
      int n;
      req <= '{o, d, s, v, f, k[1], k[0]};
      @(negedge clk);
      req <= '0;
      @(negedge clk);
      n = 0;
      while (busy === 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
   endtask : op

   // Trap or maskable event; bounded wait for any entry
   task automatic kick(input logic t);
      int n;
      if (t) trap <= 1'b1;
      else fire <= 1'b1;
      @(negedge clk);
      trap <= 1'b0;
      fire <= 1'b0;
      n = 0;
      while (busy !== 1'b1 && n < 12) begin
         @(negedge clk);
         n++;
      end
      while (busy === 1'b1 && n < 30) begin
         @(negedge clk);
         n++;
      end
   endtask : kick

   task automatic finish_test;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test

   initial begin
      logic [7:0] v;
      logic [1:0] k;
      void'($urandom(15));
      repeat (6) @(negedge clk);
      rst_b <= 1'b1;
      @(negedge clk);
      chk("flags", 16'h00e8, {8'h00, fl});
      chk("sp", 16'h01ff, sp);
      for (int i = 0; i < 12; i++) begin
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($urandom);
         k = 2'(i);
         op(OP_ALU, DST_ACC, 1'b0, v);
         chk("acc", {8'h00, v}, {8'h00, acc});
         chk("nz", {14'h0, nz(v)}, {14'h0, fl[2:1]});
         op(OP_ADD, DST_ACC, 1'b0, v, 16'h0000, k);
         chk("ch", {14'h0, k}, {14'h0, fl[0], fl[4]});
         op(OP_NONE, DST_INDEX, k[0], ~v);
         chk("index", {8'h00, ~v}, {8'h00, k[0] ? yi : xi});
      end
      op(OP_CARRY_SET);
      chk("carry", 16'h0001, {15'h0, fl[0]});
      op(OP_CARRY_CLEAR);
      chk("carry", 16'h0000, {15'h0, fl[0]});
      op(OP_MASK_SET);
      chk("mask", 16'h0001, {15'h0, fl[3]});
      op(OP_LOAD_SP_LOW, DST_NONE, 1'b0, 8'h80);
      chk("sp", 16'h0180, sp);
      op(OP_CALL, DST_NONE, 1'b0, 8'h00, 16'h1234);
      chk("sp", 16'h01fe, sp);
      op(OP_RETURN);
      chk("fetch", 16'h1234, fa);
      chk("sp", 16'h0180, sp);
      op(OP_STACK_REINIT);
      chk("sp", 16'h01ff, sp);
      op(OP_ALU, DST_ACC, 1'b0, 8'h5a);
      op(OP_NONE, DST_INDEX, 1'b0, 8'h3c);
      kick(1'b1);
      chk("sp", 16'h01fa, sp);
      chk("take", 16'h0001, 16'(take_cnt));
      kick(1'b0);
      chk("sp", 16'h01fa, sp);
      chk("take", 16'h0001, 16'(take_cnt));
      op(OP_ALU, DST_ACC, 1'b0, 8'h11);
      op(OP_NONE, DST_INDEX, 1'b0, 8'h22);
      op(OP_NONE, DST_INDEX, 1'b1, 8'h33);
      op(OP_UNMASK);
      chk("sp", 16'h01f5, sp);
      chk("take", 16'h0002, 16'(take_cnt));
      op(OP_HANDLER_RETURN);
      chk("acc", 16'h0011, {8'h00, acc});
      chk("index", 16'h2233, {xi, yi});
      chk("flags", 16'h00f0, {8'h00, fl});
      chk("sp", 16'h01fa, sp);
      op(OP_RETURN);
      chk("fetch", 16'hf85a, fa);
      op(OP_RETURN);
      chk("fetch", 16'h3c12, fa);
      chk("sp", 16'h01fe, sp);
      finish_test();
   end

   // Run needs well under a thousand cycles
   initial begin
      #(50 * 5000);
      error_cnt++;
      finish_test();
   end
endmodule : cpu_register_set_bench
`default_nettype wire
